// ---- design/pmc_defines.svh ----
// Functional notes
// - Setting the idle bit of power_control_zero halts the core, keeps peripherals clocked, and any interrupt resumes the core.
// - Suspend halts core and peripheral clocks, stops both fast oscillators and keeps the regulator in normal bias.
// - Snooze is requested like suspend through its own bit and halts the same clocks with the regulator in low bias.
// - In suspend and snooze timers 3 and 4 can still run from slow_osc_80k while all other clocks stop.
// - Suspend and snooze end on timer 4, SPI, I2C slave, port match, comparator 0 rising edge or an enabled logic-unit event.
// - Waking from suspend or snooze resumes the core where it stopped, without a reset.
// - Stop is entered with shutdown_select clear and the stop bit set, and any reset source ends it.
// - Shutdown is entered with shutdown_select set and the stop bit set, and only the reset pin or power-on reset end it.
// - Stop and shutdown switch off internal power nets while pins keep their state.
// - Each digital peripheral clock is gated off while that peripheral is not in use.
// - After reset system_clock runs from fast_osc_24m divided by 8.
// - The system clock divider offers divide by 1, 2, 4, 8, 16, 32, 64 and 128.
// - slow_osc_80k divided by 8 can be selected as clock for timers 3 and 4 in active, suspend and snooze.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// Register byte offsets
`define PMC_OFS_PWR_CTRL0 8'h00
`define PMC_OFS_PWR_CTRL1 8'h04
`define PMC_OFS_REG_CTRL 8'h08
`define PMC_OFS_CLK_SEL 8'h0C
`define PMC_OFS_PERIPH_EN 8'h10
`define PMC_OFS_TMR_CLK 8'h14
`define PMC_OFS_STATUS 8'h18
// Field positions
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_BIT_SUSPEND 0
`define PMC_BIT_SNOOZE 1
`define PMC_BIT_SHUTDOWN_SEL 0
// Reset values: fast_osc_24m, divide exponent 3 (divide by 8)
`define PMC_RST_CLK_SRC 2'h0
`define PMC_RST_CLK_DIV 3'h3
// Last slow oscillator count before a timer tick (one timer tick per 8 slow ticks)
`define PMC_SLOW_DIV 3'h7
`endif

// ---- design/pmc_pkg.sv ----
package pmc_pkg;
    // Power mode sequencer states
    typedef enum logic [2:0] {
        PMC_NORMAL,
        PMC_IDLE,
        PMC_SUSPEND,
        PMC_SNOOZE,
        PMC_WAKE,
        PMC_STOP,
        PMC_SHUTDOWN
    } pmc_state_e;
    // System clock sources
    typedef enum logic [1:0] {
        PMC_SRC_FAST24,
        PMC_SRC_FAST49,
        PMC_SRC_SLOW,
        PMC_SRC_EXT
    } pmc_src_e;
endpackage

// ---- design/pmc_power_mode_controller.sv ----
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pmc_defines.svh"
module pmc_power_mode_controller
    import pmc_pkg::*;
#(
    parameter int N_PERIPH = 8,
    parameter int N_LOGIC = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Wake and reset sources
    input wire logic irq_any,
    input wire logic timer4_event,
    input wire logic spi_activity,
    input wire logic i2c_slave_activity,
    input wire logic port_match,
    input wire logic comparator0,
    input wire logic [N_LOGIC-1:0] logic_unit_event,
    input wire logic [N_LOGIC-1:0] logic_unit_irq_en,
    input wire logic other_reset_source,
    input wire logic external_reset_pin_n,
    input wire logic power_on_reset,
    // Oscillators
    input wire logic fast_osc_ready,
    input wire logic slow_osc_tick,
    output logic fast_osc_24m_en,
    output logic fast_osc_49m_en,
    // Clock control
    output logic core_clk_en,
    output logic [N_PERIPH-1:0] periph_clk_en,
    output logic [1:0] system_clock_src,
    output logic [2:0] system_clock_div,
    output logic timer3_slow_sel,
    output logic timer4_slow_sel,
    output logic timer_slow_tick,
    // Power control
    output logic regulator_low_bias,
    output logic power_nets_on,
    output logic pin_retain,
    output logic reset_request
);

    pmc_state_e state_reg;
    pmc_state_e state_next;
    logic idle_req_reg;
    logic stop_req_reg;
    logic suspend_req_reg;
    logic snooze_req_reg;
    logic shutdown_select_reg;
    logic [1:0] clk_src_reg;
    logic [2:0] clk_div_reg;
    logic [N_PERIPH-1:0] periph_en_reg;
    logic [1:0] tmr_slow_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic cmp0_prev_reg;
    logic [2:0] slow_cnt_reg;
    logic slow_tick_reg;
    logic core_clk_reg;
    logic [N_PERIPH-1:0] periph_clk_reg;
    logic fast24_reg;
    logic fast49_reg;
    logic low_bias_reg;
    logic nets_on_reg;
    logic retain_reg;
    logic rst_req_reg;
    logic [5:0] wake_cause_reg;
    logic [5:0] wake_vec;
    logic wake_any;
    logic any_reset;
    logic pin_or_por;
    logic wr_ok;
    logic rd_take;
    logic exit_low;
    logic clks_running;

    // Bus access qualifiers
    assign wr_ok = avs_write && !wait_reg && avs_byteenable[0];
    assign rd_take = avs_read && wait_reg;

    // Wake sources of suspend and snooze
    assign wake_vec = {|(logic_unit_event & logic_unit_irq_en),
                       comparator0 && !cmp0_prev_reg,
                       port_match, i2c_slave_activity, spi_activity, timer4_event};
    assign wake_any = |wake_vec;
    assign any_reset = other_reset_source || !external_reset_pin_n || power_on_reset;
    assign pin_or_por = !external_reset_pin_n || power_on_reset;
    assign exit_low = (state_reg == PMC_WAKE) && fast_osc_ready;

    // Waitrequest: one wait cycle, then answer in the next
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            wait_reg <= 1'b1;
        else if ((avs_read || avs_write) && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    // Read data is prepared during the wait cycle so it comes from a flop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_reg <= 32'h0000_0000;
        else if (rd_take)
        begin
            if (avs_address == `PMC_OFS_PWR_CTRL0)
                rdata_reg <= {30'h0000_0000, stop_req_reg, idle_req_reg};
            else if (avs_address == `PMC_OFS_PWR_CTRL1)
                rdata_reg <= {30'h0000_0000, snooze_req_reg, suspend_req_reg};
            else if (avs_address == `PMC_OFS_REG_CTRL)
                rdata_reg <= {31'h0000_0000, shutdown_select_reg};
            else if (avs_address == `PMC_OFS_CLK_SEL)
                rdata_reg <= {26'h000_0000, clk_src_reg, 1'b0, clk_div_reg};
            else if (avs_address == `PMC_OFS_PERIPH_EN)
                rdata_reg <= 32'(periph_en_reg);
            else if (avs_address == `PMC_OFS_TMR_CLK)
                rdata_reg <= {30'h0000_0000, tmr_slow_reg};
            else if (avs_address == `PMC_OFS_STATUS)
                rdata_reg <= {19'h0_0000, wake_cause_reg, fast_osc_ready, 3'h0, 3'(state_reg)};
            else
                rdata_reg <= 32'h0000_0000; // Unmapped reads return zero
        end
    end

    // Idle and stop requests; idle cleared by hardware on exit, stop once stop or shutdown is entered
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
        end
        else if (state_reg == PMC_IDLE && irq_any)
            idle_req_reg <= 1'b0;
        else if (state_reg == PMC_STOP || state_reg == PMC_SHUTDOWN)
            stop_req_reg <= 1'b0;
        else if (wr_ok && avs_address == `PMC_OFS_PWR_CTRL0)
        begin
            idle_req_reg <= avs_writedata[`PMC_BIT_IDLE];
            stop_req_reg <= avs_writedata[`PMC_BIT_STOP];
        end
    end

    // Suspend and snooze requests; only honoured with the 24.5 MHz source selected
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            suspend_req_reg <= 1'b0;
            snooze_req_reg <= 1'b0;
        end
        else if (exit_low)
        begin
            suspend_req_reg <= 1'b0;
            snooze_req_reg <= 1'b0;
        end
        else if (wr_ok && avs_address == `PMC_OFS_PWR_CTRL1 && clk_src_reg == PMC_SRC_FAST24)
        begin
            suspend_req_reg <= avs_writedata[`PMC_BIT_SUSPEND];
            snooze_req_reg <= avs_writedata[`PMC_BIT_SNOOZE];
        end
    end

    // Regulator control: shutdown select chooses stop or shutdown
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            shutdown_select_reg <= 1'b0;
        else if (wr_ok && avs_address == `PMC_OFS_REG_CTRL)
            shutdown_select_reg <= avs_writedata[`PMC_BIT_SHUTDOWN_SEL];
    end

    // Clock source and divider; divider field picks 2**n for n = 0..7
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clk_src_reg <= `PMC_RST_CLK_SRC;
            clk_div_reg <= `PMC_RST_CLK_DIV;
        end
        else if (wr_ok && avs_address == `PMC_OFS_CLK_SEL)
        begin
            clk_div_reg <= avs_writedata[2:0];
            clk_src_reg <= avs_writedata[5:4];
        end
    end

    // Peripheral clock enables and timer clock selects
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periph_en_reg <= '0;
            tmr_slow_reg <= 2'h0;
        end
        else if (wr_ok && avs_address == `PMC_OFS_PERIPH_EN)
            periph_en_reg <= avs_writedata[N_PERIPH-1:0];
        else if (wr_ok && avs_address == `PMC_OFS_TMR_CLK)
            tmr_slow_reg <= avs_writedata[1:0];
    end

    // Mode sequencer next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PMC_NORMAL:
                if (stop_req_reg)
                    state_next = shutdown_select_reg ? PMC_SHUTDOWN : PMC_STOP;
                else if (suspend_req_reg)
                    state_next = PMC_SUSPEND;
                else if (snooze_req_reg)
                    state_next = PMC_SNOOZE;
                else if (idle_req_reg && !irq_any)
                    state_next = PMC_IDLE;
            PMC_IDLE:
                if (irq_any)
                    state_next = PMC_NORMAL;
            PMC_SUSPEND, PMC_SNOOZE:
                if (wake_any)
                    state_next = PMC_WAKE;
            PMC_WAKE:
                if (fast_osc_ready)
                    state_next = PMC_NORMAL;
            PMC_STOP:
                if (any_reset)
                    state_next = PMC_NORMAL;
            PMC_SHUTDOWN:
                if (pin_or_por)
                    state_next = PMC_NORMAL;
            default:
                state_next = PMC_NORMAL;
        endcase
    end

    // Mode state register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= PMC_NORMAL;
        else
            state_reg <= state_next;
    end

    // Latch the wake cause for software; cleared when a new suspend or snooze starts
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            wake_cause_reg <= 6'h00;
        else if ((state_reg == PMC_SUSPEND || state_reg == PMC_SNOOZE) && wake_any)
            wake_cause_reg <= wake_vec;
        else if (state_reg == PMC_NORMAL && (suspend_req_reg || snooze_req_reg))
            wake_cause_reg <= 6'h00;
    end

    // Comparator 0 edge detection
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cmp0_prev_reg <= 1'b0;
        else
            cmp0_prev_reg <= comparator0;
    end

    // Slow oscillator divided by 8 for timers 3 and 4; keeps running in every mode
    // except stop and shutdown, where the power nets are gone
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slow_cnt_reg <= 3'h0;
            slow_tick_reg <= 1'b0;
        end
        else
        begin
            slow_tick_reg <= 1'b0;
            if (slow_osc_tick && state_next != PMC_STOP && state_next != PMC_SHUTDOWN)
            begin
                slow_cnt_reg <= slow_cnt_reg + 3'h1;
                slow_tick_reg <= (slow_cnt_reg == `PMC_SLOW_DIV) && (|tmr_slow_reg);
            end
        end
    end

    // Clocks run only in normal and idle; core clock only in normal
    assign clks_running = (state_next == PMC_NORMAL) || (state_next == PMC_IDLE);

    // Clock gating outputs, registered from the next state so they track the mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            core_clk_reg <= 1'b1;
            periph_clk_reg <= '0;
        end
        else
        begin
            core_clk_reg <= (state_next == PMC_NORMAL);
            periph_clk_reg <= clks_running ? periph_en_reg : '0;
        end
    end

    // Oscillators: both fast ones stop in every low-power mode but idle; the
    // fast_osc_24m restarts during wake so clocks are stable before release
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fast24_reg <= 1'b1;
            fast49_reg <= 1'b0;
        end
        else
        begin
            fast24_reg <= clks_running ? (clk_src_reg == PMC_SRC_FAST24)
                        : (state_next == PMC_WAKE);
            fast49_reg <= clks_running && (clk_src_reg == PMC_SRC_FAST49);
        end
    end

    // Regulator bias, power nets, pin retention and reset request
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            low_bias_reg <= 1'b0;
            nets_on_reg <= 1'b1;
            retain_reg <= 1'b0;
            rst_req_reg <= 1'b0;
        end
        else
        begin
            low_bias_reg <= (state_next == PMC_SNOOZE);
            nets_on_reg <= (state_next != PMC_STOP) && (state_next != PMC_SHUTDOWN);
            retain_reg <= (state_next == PMC_STOP) || (state_next == PMC_SHUTDOWN);
            // Leaving stop or shutdown restarts the chip; suspend wake never does
            rst_req_reg <= ((state_reg == PMC_STOP) || (state_reg == PMC_SHUTDOWN))
                        && (state_next == PMC_NORMAL);
        end
    end

    // Outputs straight from flops
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign core_clk_en = core_clk_reg;
    assign periph_clk_en = periph_clk_reg;
    assign fast_osc_24m_en = fast24_reg;
    assign fast_osc_49m_en = fast49_reg;
    assign system_clock_src = clk_src_reg;
    assign system_clock_div = clk_div_reg;
    assign timer3_slow_sel = tmr_slow_reg[0];
    assign timer4_slow_sel = tmr_slow_reg[1];
    assign timer_slow_tick = slow_tick_reg;
    assign regulator_low_bias = low_bias_reg;
    assign power_nets_on = nets_on_reg;
    assign pin_retain = retain_reg;
    assign reset_request = rst_req_reg;

endmodule

// ---- sim/pmc_osc_model.sv ----
`timescale 1ns/100ps
module pmc_osc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Enables from the controller
    input wire logic fast_osc_24m_en,
    input wire logic fast_osc_49m_en,
    // Oscillator status
    output logic fast_osc_ready,
    output logic slow_osc_tick
);
    logic [2:0] settle_reg;
    logic [2:0] slow_reg;
    // Ready drops at once when stopped, so a wake must wait for settling
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            settle_reg <= 3'h0;
        else if (!(fast_osc_24m_en || fast_osc_49m_en))
            settle_reg <= 3'h0;
        else if (settle_reg != 3'h4)
            settle_reg <= settle_reg + 3'h1;
    assign fast_osc_ready = (settle_reg == 3'h4);
    // Slow oscillator runs free in every mode, one tick per five cycles
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            slow_reg <= 3'h0;
        else
            slow_reg <= (slow_reg == 3'h4) ? 3'h0 : slow_reg + 3'h1;
    assign slow_osc_tick = (slow_reg == 3'h4);
endmodule

// ---- sim/pmc_sva.sv ----
`timescale 1ns/100ps
module pmc_sva #(
    parameter int N_PERIPH = 8
)
(
    // Clock, reset and bus handshake
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic irq_any,
    // Clock and power outputs
    input wire logic core_clk_en,
    input wire logic [N_PERIPH-1:0] periph_clk_en,
    input wire logic fast_osc_24m_en,
    input wire logic fast_osc_49m_en,
    input wire logic [1:0] system_clock_src,
    input wire logic [2:0] system_clock_div,
    input wire logic timer3_slow_sel,
    input wire logic timer4_slow_sel,
    input wire logic timer_slow_tick,
    input wire logic regulator_low_bias,
    input wire logic power_nets_on,
    input wire logic pin_retain,
    input wire logic reset_request
);
    // All checks share the one clock domain
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Bus answers after exactly one wait cycle and only for one cycle
    AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    AST_BUS_ONE_CYCLE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // Release of reset must leave the fast source divided by 8
    AST_RESET_CLOCK: assert property ($past(sys_rst) |-> system_clock_src == 2'h0 && system_clock_div == 3'h3)
        else $error("system clock not fast source divided by 8 after reset");
    // Idle only when no interrupt was pending, peripherals untouched
    AST_IDLE_ENTRY: assert property ($fell(core_clk_en) && fast_osc_24m_en && power_nets_on |-> $past(irq_any) == 1'b0 && $stable(periph_clk_en))
        else $error("idle entry wrong");
    AST_SUSPEND_GATES: assert property (!core_clk_en && !fast_osc_24m_en && power_nets_on && system_clock_src == 2'h0 |-> periph_clk_en == '0 && !fast_osc_49m_en)
        else $error("suspend leaves a clock or oscillator running");
    AST_LOW_BIAS: assert property (regulator_low_bias |-> !core_clk_en && !fast_osc_24m_en && !fast_osc_49m_en)
        else $error("low bias outside snooze");
    AST_POWER_OFF: assert property (!power_nets_on |-> pin_retain && !core_clk_en)
        else $error("power nets off without pin retention");
    AST_EXIT_PULSE: assert property (reset_request |-> power_nets_on && $past(power_nets_on) == 1'b0 ##1 !reset_request)
        else $error("reset request not a single pulse on leaving stop");
    AST_SLOW_TICK: assert property (timer_slow_tick |-> (timer3_slow_sel || timer4_slow_sel || $past(timer3_slow_sel) || $past(timer4_slow_sel)) ##1 !timer_slow_tick)
        else $error("slow timer tick without a select");
    AST_WAKE_OSC: assert property ($rose(core_clk_en) |-> fast_osc_24m_en || fast_osc_49m_en)
        else $error("core released before oscillator restart");

    // Main scenarios reached
    COV_SNOOZE: cover property (regulator_low_bias);
    COV_STOP: cover property ($fell(power_nets_on));
    COV_TICK: cover property (timer_slow_tick);
    COV_WAKE: cover property ($rose(core_clk_en));
endmodule

bind pmc_power_mode_controller pmc_sva #(.N_PERIPH(N_PERIPH)) u_sva (
    .clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .irq_any, .core_clk_en,
    .periph_clk_en, .fast_osc_24m_en, .fast_osc_49m_en, .system_clock_src, .system_clock_div,
    .timer3_slow_sel, .timer4_slow_sel, .timer_slow_tick, .regulator_low_bias, .power_nets_on,
    .pin_retain, .reset_request
);

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`include "pmc_defines.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb;
    import pmc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] q;} pmc_row_s;
    // Stimulus
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, irq_any = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF, logic_unit_irq_en = 4'h0;
    logic [5:0] wk = 6'h00;
    logic [2:0] rs = 3'h0;
    // Observed
    logic [31:0] avs_readdata, q;
    logic [7:0] periph_clk_en;
    logic [3:0] logic_unit_event;
    logic [2:0] system_clock_div;
    logic [1:0] system_clock_src;
    logic avs_waitrequest, fast_osc_ready, slow_osc_tick, fast_osc_24m_en, fast_osc_49m_en;
    logic core_clk_en, timer3_slow_sel, timer4_slow_sel, timer_slow_tick, regulator_low_bias;
    logic power_nets_on, pin_retain, reset_request, timer4_event, spi_activity;
    logic i2c_slave_activity, port_match, comparator0, other_reset_source;
    logic external_reset_pin_n, power_on_reset;
    int n_errors = 0, n_checks = 0, n_slow = 0, n_tt = 0, n_rr = 0, r, i, m, w, s, k;
    pmc_row_s rows [10] = '{'{8'h10, 32'hA5, 4'hF, 32'hA5}, '{8'h10, 32'hFF, 4'h0, 32'hA5},
        '{8'h14, 32'h3, 4'h1, 32'h3}, '{8'h14, 32'h0, 4'hF, 32'h0}, '{8'h08, 32'h1, 4'hF, 32'h1},
        '{8'h08, 32'h0, 4'hF, 32'h0}, '{8'hFC, 32'h55, 4'hF, 32'h0}, '{8'h0C, 32'h33, 4'hF, 32'h33},
        '{8'h0C, 32'h13, 4'hF, 32'h13}, '{8'h0C, 32'h3, 4'hF, 32'h3}};

    // Wake lines and reset sources as vectors so loops can walk them
    assign {timer4_event, spi_activity, i2c_slave_activity, port_match, comparator0} = wk[5:1];
    assign logic_unit_event = {4{wk[0]}};
    assign {power_on_reset, external_reset_pin_n, other_reset_source} = {rs[2], !rs[1], rs[0]};

    always #5 clk = ~clk;

    pmc_power_mode_controller dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_any, .timer4_event,
        .spi_activity, .i2c_slave_activity, .port_match, .comparator0, .logic_unit_event,
        .logic_unit_irq_en, .other_reset_source, .external_reset_pin_n, .power_on_reset,
        .fast_osc_ready, .slow_osc_tick, .fast_osc_24m_en, .fast_osc_49m_en, .core_clk_en,
        .periph_clk_en, .system_clock_src, .system_clock_div, .timer3_slow_sel,
        .timer4_slow_sel, .timer_slow_tick, .regulator_low_bias, .power_nets_on, .pin_retain,
        .reset_request);
    pmc_osc_model u_osc (.clk, .sys_rst, .fast_osc_24m_en, .fast_osc_49m_en, .fast_osc_ready,
        .slow_osc_tick);

    // Pulse counters sampled mid-cycle, away from the launching edge
    always @(negedge clk)
    begin
        n_slow += (slow_osc_tick === 1'b1);
        n_tt += (timer_slow_tick === 1'b1);
        n_rr += (reset_request === 1'b1);
    end

    // One Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] rd);
        int t;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        for (t = 0; t < 20; t++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        `CHK(avs_waitrequest, 1'b0)
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Two quiet edges: no re-raise in the release step, and mode outputs settle
        @(posedge clk);
        @(posedge clk);
    endtask

    // Bounded wait; the caller compares afterwards
    task automatic wait_core(input logic v);
        int t;
        for (t = 0; t < 40 && core_clk_en !== v; t++)
            @(posedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the fewer than a thousand cycles the tests need
    initial
    begin
        repeat (30000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK({system_clock_src, system_clock_div}, 5'h03)
        `CHK({core_clk_en, fast_osc_24m_en, fast_osc_49m_en, power_nets_on}, 4'hD)
        `CHK(periph_clk_en, 8'h00)
        // Register rows: write, read back, unmapped and masked lanes
        foreach (rows[j])
        begin
            bus(1'b1, rows[j].a, rows[j].d, rows[j].be, q);
            bus(1'b0, rows[j].a, 32'h0, 4'hF, q);
            `CHK(q, rows[j].q)
        end
        `CHK(periph_clk_en, 8'hA5)
        for (i = 0; i < 8; i++)
        begin
            bus(1'b1, `PMC_OFS_CLK_SEL, 32'(i), 4'hF, q);
            `CHK(system_clock_div, 3'(i))
        end
        bus(1'b1, `PMC_OFS_CLK_SEL, 32'h3, 4'hF, q);
        // Idle held off by a pending interrupt, then entered and left
        irq_any <= 1'b1;
        bus(1'b1, `PMC_OFS_PWR_CTRL0, 32'h1, 4'hF, q);
        `CHK(core_clk_en, 1'b1)
        irq_any <= 1'b0;
        bus(1'b1, `PMC_OFS_PWR_CTRL0, 32'h1, 4'hF, q);
        wait_core(1'b0);
        `CHK({core_clk_en, periph_clk_en}, 9'h0A5)
        irq_any <= 1'b1;
        wait_core(1'b1);
        irq_any <= 1'b0;
        `CHK(core_clk_en, 1'b1)
        bus(1'b0, `PMC_OFS_PWR_CTRL0, 32'h0, 4'hF, q);
        `CHK(q[1:0], 2'h0)
        // Suspend and snooze, each woken by every wake source
        logic_unit_irq_en <= 4'h8;
        for (m = 0; m < 2; m++)
            for (w = 0; w < 6; w++)
            begin
                bus(1'b1, `PMC_OFS_PWR_CTRL1, 32'(1 << m), 4'hF, q);
                `CHK({core_clk_en, periph_clk_en, fast_osc_24m_en, fast_osc_49m_en}, 11'h0)
                `CHK(regulator_low_bias, 1'(m))
                r = n_rr;
                wk <= 6'h1 << w;
                wait_core(1'b1);
                wk <= 6'h00;
                `CHK(core_clk_en, 1'b1)
                `CHK(n_rr, r)
                `CHK(periph_clk_en, 8'hA5)
                bus(1'b0, `PMC_OFS_STATUS, 32'h0, 4'hF, q);
                `CHK(q[12:0], {6'h20 >> w, 7'h40})
                bus(1'b0, `PMC_OFS_PWR_CTRL1, 32'h0, 4'hF, q);
                `CHK(q[1:0], 2'h0)
            end
        // Suspend refused while not on the 24.5 MHz source
        bus(1'b1, `PMC_OFS_CLK_SEL, 32'h13, 4'hF, q);
        bus(1'b1, `PMC_OFS_PWR_CTRL1, 32'h1, 4'hF, q);
        `CHK(core_clk_en, 1'b1)
        bus(1'b1, `PMC_OFS_CLK_SEL, 32'h3, 4'hF, q);
        // Slow timer clock keeps running through suspend
        bus(1'b1, `PMC_OFS_TMR_CLK, 32'h2, 4'hF, q);
        bus(1'b1, `PMC_OFS_PWR_CTRL1, 32'h1, 4'hF, q);
        n_slow = 0;
        n_tt = 0;
        repeat (400) @(posedge clk);
        `CHK({timer3_slow_sel, timer4_slow_sel, core_clk_en}, 3'h2)
        `CHK(n_tt >= n_slow / 8 - 1 && n_tt <= n_slow / 8 + 1, 1'b1)
        wk <= 6'h20;
        wait_core(1'b1);
        wk <= 6'h00;
        // Stop ends on any reset source, shutdown only on pin or power-on
        for (s = 0; s < 2; s++)
            for (k = 0; k < 3; k++)
            begin
                bus(1'b1, `PMC_OFS_REG_CTRL, 32'(s), 4'hF, q);
                bus(1'b1, `PMC_OFS_PWR_CTRL0, 32'h2, 4'hF, q);
                `CHK({power_nets_on, pin_retain}, 2'h1)
                r = n_rr;
                rs <= 3'h1 << k;
                @(posedge clk);
                rs <= 3'h0;
                repeat (3) @(posedge clk);
                if (s == 1 && k == 0)
                begin
                    `CHK(power_nets_on, 1'b0)
                    rs <= 3'h2;
                    @(posedge clk);
                    rs <= 3'h0;
                    repeat (3) @(posedge clk);
                end
                `CHK(power_nets_on, 1'b1)
                `CHK(n_rr, r + 1)
            end
        bus(1'b1, `PMC_OFS_REG_CTRL, 32'h0, 4'hF, q);
        // Reset in mid-run restores the divider
        bus(1'b1, `PMC_OFS_CLK_SEL, 32'h7, 4'hF, q);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK(system_clock_div, 3'h3)
        complete_run();
    end
endmodule
